// File: core/lfrs_selector.sv
/*
 * Fault-response selector: three fault classes, action selection, latch and
 * retry recovery, retry limit, fault pin, flags and interrupt, AXI4-Lite slave.
 * Assumes fault inputs synchronous to aclk and a single AXI4-Lite master.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module lfrs_selector
	import lfrs_pkg::*;
#(
	parameter int RETRY_CYCLES = LOCK_RETRY_CYCLES
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        regulator_overcurrent,
	input  wire logic        abnormal_speed,
	input  wire logic        no_motor,
	input  wire logic        abnormal_bemf,
	input  wire logic        hw_limit_exceeded,
	input  wire logic        sw_limit_exceeded,
	output logic [2:0]       phase_hs_on,
	output logic [2:0]       phase_ls_on,
	output logic             stage_hiz,
	output logic             core_disable,
	output logic             fault_indicator_n,
	output logic             irq
);
	// Retry wait needs a cycle
	if (RETRY_CYCLES < 1)
	begin : g_bad_retry
		$error("RETRY_CYCLES must be at least one");
	end

	logic [31:0]          config_reg;
	logic [NUM_FLAGS-1:0] controller_fault_flags;
	logic [NUM_FLAGS-1:0] mask;
	logic [2:0]           retry_count;
	logic [31:0]          retry_timer;
	logic [1:0]           kind;
	lfrs_state_e          state;

	// Bus decode
	wire logic        wr_go;
	wire logic        rd_go;
	wire logic [31:0] byte_mask;
	wire logic [31:0] next_config;
	wire logic        wr_config;
	wire logic        wr_command;
	wire logic        wr_flags;
	wire logic        wr_mask;
	wire logic        wr_hit;
	wire logic        rd_hit;
	wire logic [31:0] state_word;
	wire logic [31:0] rd_word;
	wire logic        clear_fault_cmd;
	wire logic        retry_counter_clear;

	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = s_axi_awready;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign byte_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	assign next_config = ((config_reg & ~byte_mask) | (s_axi_wdata & byte_mask)) & CONFIG_MASK;
	assign wr_config = wr_go && (s_axi_awaddr == ADDR_CONFIG);
	assign wr_command = wr_go && (s_axi_awaddr == ADDR_COMMAND) && s_axi_wstrb[0];
	assign wr_flags = wr_go && (s_axi_awaddr == ADDR_FLAGS) && s_axi_wstrb[0];
	assign wr_mask = wr_go && (s_axi_awaddr == ADDR_MASK) && s_axi_wstrb[0];
	assign wr_hit = (s_axi_awaddr == ADDR_CONFIG) || (s_axi_awaddr == ADDR_COMMAND)
		|| (s_axi_awaddr == ADDR_FLAGS) || (s_axi_awaddr == ADDR_MASK)
		|| (s_axi_awaddr == ADDR_STATE);
	assign rd_hit = (s_axi_araddr == ADDR_CONFIG) || (s_axi_araddr == ADDR_COMMAND)
		|| (s_axi_araddr == ADDR_FLAGS) || (s_axi_araddr == ADDR_MASK)
		|| (s_axi_araddr == ADDR_STATE);
	assign clear_fault_cmd = wr_command && s_axi_wdata[CMD_CLEAR_BIT];
	assign retry_counter_clear = wr_command && s_axi_wdata[CMD_RETRY_CLR_BIT];
	assign state_word = {14'h0, fault_indicator_n, regulator_overcurrent, 5'h0,
		retry_count, 2'h0, kind, 1'h0, state};
	assign rd_word = (s_axi_araddr == ADDR_CONFIG) ? config_reg :
		(s_axi_araddr == ADDR_FLAGS) ? {28'h0, controller_fault_flags} :
		(s_axi_araddr == ADDR_MASK) ? {28'h0, mask} :
		(s_axi_araddr == ADDR_STATE) ? state_word : 32'h0;

	// Fault classes
	wire logic       motor_lock_fault;
	wire logic [2:0] motor_lock_action_sel;
	wire logic [2:0] hw_current_limit_action_sel;
	wire logic [2:0] sw_current_limit_action_sel;
	wire logic [2:0] retry_limit;
	wire logic [2:0] c_latch;
	wire logic [2:0] c_retry;
	wire logic [2:0] c_report;
	wire logic [1:0] c_kind [3];

	assign motor_lock_fault = abnormal_speed || no_motor || abnormal_bemf;
	assign motor_lock_action_sel = config_reg[MOTOR_SEL_LSB +: 3];
	assign hw_current_limit_action_sel = config_reg[HW_SEL_LSB +: 3];
	assign sw_current_limit_action_sel = config_reg[SW_SEL_LSB +: 3];
	assign retry_limit = config_reg[RETRY_LIM_LSB +: 3];

	lfrs_class_decode u_motor (.cond(motor_lock_fault), .sel(motor_lock_action_sel),
		.act_latch(c_latch[0]), .act_retry(c_retry[0]), .act_report(c_report[0]),
		.kind(c_kind[0]));
	lfrs_class_decode u_hw (.cond(hw_limit_exceeded), .sel(hw_current_limit_action_sel),
		.act_latch(c_latch[1]), .act_retry(c_retry[1]), .act_report(c_report[1]),
		.kind(c_kind[1]));
	lfrs_class_decode u_sw (.cond(sw_limit_exceeded), .sel(sw_current_limit_action_sel),
		.act_latch(c_latch[2]), .act_retry(c_retry[2]), .act_report(c_report[2]),
		.kind(c_kind[2]));

	wire logic       any_latch;
	wire logic       any_retry;
	wire logic [1:0] latch_kind;
	wire logic [1:0] retry_kind;
	wire logic       timer_done;
	wire logic       limit_hit;
	wire logic [2:0] count_inc;

	assign any_latch = |c_latch;
	assign any_retry = |c_retry;
	assign latch_kind = c_latch[0] ? c_kind[0] : c_latch[1] ? c_kind[1] : c_kind[2];
	assign retry_kind = c_retry[0] ? c_kind[0] : c_retry[1] ? c_kind[1] : c_kind[2];
	assign timer_done = (retry_timer == 32'(RETRY_CYCLES - 1));
	assign count_inc = (retry_count == 3'h7) ? retry_count : retry_count + 3'h1;
	assign limit_hit = (retry_limit != 3'h0) && (count_inc >= retry_limit);

	lfrs_state_e next_state;
	logic [1:0]  next_kind;
	logic [31:0] next_timer;
	logic        next_limit_flag;

	always_comb
	begin
		next_state = state;
		next_kind = kind;
		next_timer = retry_timer;
		next_limit_flag = 1'b0;
		case (state)
			ST_RUN:
			begin
				if (any_latch)
				begin
					next_state = ST_LATCH;
					next_kind = latch_kind;
				end
				else if (any_retry)
				begin
					next_state = ST_RETRY;
					next_kind = retry_kind;
					next_timer = 32'h0;
				end
			end
			ST_RETRY:
			begin
				if (any_latch)
				begin
					next_state = ST_LATCH;
					next_kind = latch_kind;
				end
				else if (any_retry)
					next_timer = 32'h0;
				else if (timer_done)
				begin
					next_state = limit_hit ? ST_LATCH : ST_RUN;
					next_limit_flag = limit_hit;
				end
				else
					next_timer = retry_timer + 32'h1;
			end
			ST_LATCH:
			begin
				if (clear_fault_cmd && !any_latch)
					next_state = ST_RUN;
			end
			default:
				next_state = ST_RUN;
		endcase
	end

	wire logic       acting;
	wire logic [2:0] next_hs;
	wire logic [2:0] next_ls;
	wire logic [NUM_FLAGS-1:0] flag_set;

	assign acting = (next_state != ST_RUN);
	assign next_hs = (acting && next_kind == KIND_HS && !regulator_overcurrent) ? 3'h7 : 3'h0;
	assign next_ls = (acting && next_kind == KIND_LS && !regulator_overcurrent) ? 3'h7 : 3'h0;
	assign flag_set = {next_limit_flag, c_report};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_RUN;
			kind <= KIND_HIZ;
			retry_timer <= 32'h0;
			retry_count <= 3'h0;
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			retry_timer <= next_timer;
			if (retry_counter_clear)
				retry_count <= 3'h0;
			else if (state == ST_RETRY && !any_latch && !any_retry && timer_done)
				retry_count <= count_inc;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_hs_on <= 3'h0;
			phase_ls_on <= 3'h0;
			stage_hiz <= 1'b0;
			core_disable <= 1'b0;
			fault_indicator_n <= 1'b1;
		end
		else
		begin
			phase_hs_on <= next_hs;
			phase_ls_on <= next_ls;
			stage_hiz <= regulator_overcurrent || (acting && next_kind == KIND_HIZ);
			core_disable <= regulator_overcurrent;
			fault_indicator_n <= !(acting || (|c_report));
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			config_reg <= CONFIG_RESET;
			mask <= MASK_RESET;
			controller_fault_flags <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_config)
				config_reg <= next_config;
			if (wr_mask)
				mask <= s_axi_wdata[NUM_FLAGS-1:0];
			controller_fault_flags <= flag_set | (controller_fault_flags
				& ~(wr_flags ? s_axi_wdata[NUM_FLAGS-1:0] : '0));
			irq <= |(controller_fault_flags & mask);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0;
		end
		else
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	regoc_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
		regulator_overcurrent |=> stage_hiz && core_disable && phase_hs_on == 3'h0
			&& phase_ls_on == 3'h0)
		else $error("regulator overcurrent did not force Hi-Z");
	lock_detect_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(abnormal_bemf && motor_lock_action_sel == 3'h0) |=> state == ST_LATCH)
		else $error("back-EMF lock did not latch");
	ignore_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == ST_RUN && motor_lock_action_sel == SEL_IGNORE && !hw_limit_exceeded
			&& !sw_limit_exceeded) |=> state == ST_RUN
			&& !$rose(controller_fault_flags[FLAG_MOTOR]))
		else $error("ignored motor lock took action");
	hw_report_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(hw_limit_exceeded && hw_current_limit_action_sel == SEL_REPORT)
			|=> controller_fault_flags[FLAG_HW] && !fault_indicator_n)
		else $error("report-only hardware limit not reported");
	sw_retry_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == ST_RUN && sw_limit_exceeded && sw_current_limit_action_sel == 3'h4
			&& !any_latch && !c_retry[0] && !c_retry[1] && !regulator_overcurrent)
			|=> state == ST_RETRY && phase_ls_on == 3'h7)
		else $error("software limit retry brake wrong");
	latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == ST_LATCH && !clear_fault_cmd) |=> state == ST_LATCH)
		else $error("latched fault released without clear");
	latch_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state != ST_LATCH && any_latch && any_retry)
			|=> state == ST_LATCH && kind == $past(latch_kind))
		else $error("latched fault lost priority");
	limit_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == ST_RETRY && !any_latch && !any_retry && timer_done && limit_hit)
			|=> state == ST_LATCH && controller_fault_flags[FLAG_LIMIT])
		else $error("retry limit did not latch");
	pin_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state != ST_RUN) |-> !fault_indicator_n)
		else $error("actionable fault not on fault pin");
	brake_side_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(next_state == ST_LATCH && next_kind == KIND_HS && !regulator_overcurrent)
			|=> phase_hs_on == 3'h7 && phase_ls_on == 3'h0)
		else $error("high-side brake pattern wrong");
endmodule : lfrs_selector
`default_nettype wire

// File: core/lfrs_pkg.sv
/*
 * Constants shared by the fault-response selector: register map, field
 * layout, reset values, action codes, states and timing.
 * Assumes a 40 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package lfrs_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_STATE = 8'h10;
	// Config field positions
	localparam int MOTOR_SEL_LSB = 0;
	localparam int HW_SEL_LSB = 4;
	localparam int SW_SEL_LSB = 8;
	localparam int RETRY_LIM_LSB = 12;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] CONFIG_MASK = 32'h0000_7777;
	// Command bits
	localparam int CMD_CLEAR_BIT = 0;
	localparam int CMD_RETRY_CLR_BIT = 1;
	// Flag bits
	localparam int NUM_FLAGS = 4;
	localparam int FLAG_MOTOR = 0;
	localparam int FLAG_HW = 1;
	localparam int FLAG_SW = 2;
	localparam int FLAG_LIMIT = 3;
	localparam logic [NUM_FLAGS-1:0] MASK_RESET = 4'h0;
	// Action select codes
	localparam logic [2:0] SEL_RETRY_FIRST = 3'h3;
	localparam logic [2:0] SEL_REPORT = 3'h6;
	localparam logic [2:0] SEL_IGNORE = 3'h7;
	// Output action kinds
	localparam logic [1:0] KIND_HIZ = 2'h0;
	localparam logic [1:0] KIND_LS = 2'h1;
	localparam logic [1:0] KIND_HS = 2'h2;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int LOCK_RETRY_TIME_US = 100000;
	localparam int LOCK_RETRY_CYCLES = LOCK_RETRY_TIME_US * CLK_MHZ;

	typedef enum logic [2:0]
	{
		ST_RUN = 3'h1,
		ST_RETRY = 3'h2,
		ST_LATCH = 3'h4
	} lfrs_state_e;
endpackage : lfrs_pkg

// File: core/lfrs_class_decode.sv
/*
 * Decodes one fault class: condition plus three-bit action select into
 * latched, retry, report and output kind.
 * Assumes the condition is already synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module lfrs_class_decode
	import lfrs_pkg::*;
(
	input  wire logic       cond,
	input  wire logic [2:0] sel,
	output logic            act_latch,
	output logic            act_retry,
	output logic            act_report,
	output logic [1:0]      kind
);
	wire logic is_latch_code;
	wire logic is_retry_code;
	wire logic [2:0] retry_base;

	assign is_latch_code = (sel < SEL_RETRY_FIRST);
	assign is_retry_code = (sel >= SEL_RETRY_FIRST) && (sel < SEL_REPORT);
	assign retry_base = sel - SEL_RETRY_FIRST;
	assign act_latch = cond && is_latch_code;
	assign act_retry = cond && is_retry_code;
	assign act_report = cond && (sel != SEL_IGNORE);
	assign kind = is_latch_code ? sel[1:0] : retry_base[1:0];
endmodule : lfrs_class_decode
`default_nettype wire

// File: test/lfrs_host_model.sv
/*
 * Host controller model: AXI4-Lite master issuing register accesses.
 * Assumes one slave on aclk; the bench calls wr and rd in turn.
 */
`timescale 1ns/1ps
`default_nettype none
module lfrs_host_model
(
	input  wire logic        aclk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [7:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Each channel released when taken
		do
		begin
			@(posedge aclk);
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!(aw_done && w_done));
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : lfrs_host_model
`default_nettype wire

// File: test/tb.sv
/*
 * Bench for the fault-response selector: register, fault and interrupt tests.
 * Assumes the host model as bus master and a shortened retry time.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
	import lfrs_pkg::*;
;
	localparam int RC = 8;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [1:0]  bresp, rresp, resp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [2:0]  lock_src = 3'h0;
	logic        hw_c = 1'b0, sw_c = 1'b0, reg_oc = 1'b0;
	logic [2:0]  hs, ls;
	logic        hiz, cdis, fn, irq;
	logic [9:0]  pins;
	int          n_errors = 0, checks_done = 0, cycles = 0, k;

	always #12.5 aclk = ~aclk;
	assign pins = {hs, ls, hiz, cdis, fn, irq};

	lfrs_selector #(.RETRY_CYCLES(RC)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .regulator_overcurrent(reg_oc),
		.abnormal_speed(lock_src[0]), .no_motor(lock_src[1]), .abnormal_bemf(lock_src[2]),
		.hw_limit_exceeded(hw_c), .sw_limit_exceeded(sw_c), .phase_hs_on(hs),
		.phase_ls_on(ls), .stage_hiz(hiz), .core_disable(cdis),
		.fault_indicator_n(fn), .irq(irq));

	lfrs_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	task automatic print_verdict;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors = n_errors + 1;
			print_verdict();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_pins(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t pins got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pins

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		host.wr(a, d, resp);
		chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
	endtask : wr_ok

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host.rd(a, rv, resp);
		chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
		chk_word(rv, exp);
	endtask : rd_chk

	// Expected pins: k 0 Hi-Z, 1 low brake, 2 high brake, 3 none
	function automatic logic [9:0] act(input int k, input logic f);
		return {(k == 2) ? 3'h7 : 3'h0, (k == 1) ? 3'h7 : 3'h0, k == 0, 1'b0, f, 1'b0};
	endfunction : act

	task automatic set_cond(input int c, input int code, input logic v);
		case (c)
			0: lock_src <= v ? 3'(3'h4 >> (code % 3)) : 3'h0;
			1: hw_c <= v;
			default: sw_c <= v;
		endcase
	endtask : set_cond

	initial
	begin
		tick(20);
		aresetn <= 1'b1;
		rd_chk(ADDR_CONFIG, 32'h0);
		rd_chk(ADDR_MASK, 32'h0);
		rd_chk(ADDR_FLAGS, 32'h0);
		rd_chk(ADDR_COMMAND, 32'h0);
		rd_chk(ADDR_STATE, 32'h0002_0001);
		host.rd(8'h14, rv, resp);
		chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
		host.wr(8'h14, 32'hffff_ffff, resp);
		chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
		rd_chk(ADDR_CONFIG, 32'h0);
		reg_oc <= 1'b1;
		tick(3);
		chk_pins(pins, 10'h00e);
		rd_chk(ADDR_FLAGS, 32'h0);
		rd_chk(ADDR_STATE, 32'h0003_0001);
		reg_oc <= 1'b0;
		tick(3);
		chk_pins(pins, act(3, 1));
		for (int c = 0; c < 3; c++)
			for (int code = 0; code < 8; code++)
			begin
				wr_ok(ADDR_CONFIG, 32'(code) << (4 * c));
				set_cond(c, code, 1'b1);
				tick(2);
				k = (code < 6) ? code % 3 : 3;
				chk_pins(pins, act(k, code == 7));
				rd_chk(ADDR_FLAGS, (code < 7) ? 32'h1 << c : 32'h0);
				set_cond(c, code, 1'b0);
				tick(2);
				if (code < 6)
					chk_pins(pins, act(k, 0));
				if (code < 3)
					wr_ok(ADDR_COMMAND, 32'h1);
				else if (code < 6)
					tick(RC);
				tick(2);
				chk_pins(pins, act(3, 1));
				wr_ok(ADDR_FLAGS, 32'hf);
			end
		wr_ok(ADDR_CONFIG, 32'h0000_0501);
		set_cond(0, 1, 1'b1);
		set_cond(2, 5, 1'b1);
		tick(2);
		chk_pins(pins, act(1, 0));
		rd_chk(ADDR_STATE, 32'h0000_0714);
		set_cond(0, 1, 1'b0);
		set_cond(2, 5, 1'b0);
		tick(RC + 4);
		chk_pins(pins, act(1, 0));
		wr_ok(ADDR_COMMAND, 32'h1);
		tick(2);
		chk_pins(pins, act(3, 1));
		wr_ok(ADDR_FLAGS, 32'hf);
		wr_ok(ADDR_COMMAND, 32'h2);
		wr_ok(ADDR_CONFIG, 32'h0000_2300);
		for (int i = 0; i < 2; i++)
		begin
			set_cond(2, 3, 1'b1);
			tick(2);
			set_cond(2, 3, 1'b0);
			tick(RC + 4);
			chk_pins(pins, (i == 0) ? act(3, 1) : act(0, 0));
		end
		rd_chk(ADDR_FLAGS, 32'hc);
		wr_ok(ADDR_COMMAND, 32'h3);
		tick(2);
		chk_pins(pins, act(3, 1));
		rd_chk(ADDR_STATE, 32'h0002_0001);
		wr_ok(ADDR_FLAGS, 32'hf);
		wr_ok(ADDR_MASK, 32'h4);
		wr_ok(ADDR_CONFIG, 32'h0000_0600);
		set_cond(2, 6, 1'b1);
		tick(3);
		chk_pins(pins, 10'h001);
		set_cond(2, 6, 1'b0);
		tick(2);
		chk_pins(pins, 10'h003);
		wr_ok(ADDR_FLAGS, 32'h4);
		tick(2);
		chk_pins(pins, act(3, 1));
		print_verdict();
	end
endmodule : tb
`default_nettype wire
